// ==== wwpc_top.sv ====
// window watchdog core with pin configuration, apb registers and interrupt
// What this block does
// - the two window selects and the timeout strap choose the window ratio and timeout, or turn the watchdog off.
// - with a capacitor on the reset-delay input the reset low time comes from the capacitor setting.
// - with the reset-delay input pulled up or open a preset reset delay is used.
// - after power-up every kick is ignored until the reset delay has run out.
// - while the reset output is low every kick is ignored.
// - while the watchdog is turned off every kick is ignored.
// - a timeout drives the reset output low for the chosen reset delay and then releases it.
// - while the watchdog is off the reset output stays high whatever the kick input does.
// - the timeout strap sets the upper boundary and the selects set the lower boundary as a half, quarter or eighth of it.
`timescale 1ns/1ps
module wwpc_top #(
  parameter logic [31:0] UPPER_PULLUP_CYC = wwpc_pkg::UPPER_PULLUP_US * wwpc_pkg::CLK_MHZ, // preset upper bound
  parameter logic [31:0] UPPER_OPEN_CYC   = wwpc_pkg::UPPER_OPEN_US * wwpc_pkg::CLK_MHZ,   // preset upper bound
  parameter logic [31:0] RST_PULLUP_CYC   = wwpc_pkg::RST_PULLUP_US * wwpc_pkg::CLK_MHZ,   // preset reset delay
  parameter logic [31:0] RST_OPEN_CYC     = wwpc_pkg::RST_OPEN_US * wwpc_pkg::CLK_MHZ      // preset reset delay
) (
  input  wire logic        ref_clk,                   // 200 MHz system clock
  input  wire logic        nrst,                      // synchronous reset, active low
  input  wire logic        window_select_a,           // window select pin a
  input  wire logic        window_select_b,           // window select pin b
  input  wire logic [1:0]  timeout_program_input,     // timeout strap: 0 cap, 1 pull-up, else open
  input  wire logic [1:0]  reset_delay_program_input, // reset-delay strap: 0 cap, 1 pull-up, else open
  input  wire logic        kick_input,                // watchdog kick pin
  output logic             reset_out_n,               // watchdog reset, active low
  output logic             reset_out_oe,              // open-drain enable, high while pulling low
  input  wire logic        psel,                      // apb select
  input  wire logic        penable,                   // apb enable
  input  wire logic        pwrite,                    // apb direction
  input  wire logic [7:0]  paddr,                     // apb byte address
  input  wire logic [31:0] pwdata,                    // apb write data
  output logic             pready,                    // apb ready
  output logic      [31:0] prdata,                    // apb read data
  output logic             pslverr,                   // apb error for unmapped address
  output logic             irq                        // level interrupt
);

  typedef struct packed {
    wwpc_pkg::wwpc_phase_t      phase;    // watchdog phase
    logic                       rstOutN;  // reset output level
    logic                       rstOe;    // open-drain enable, inverse of rstOutN
    logic [wwpc_pkg::EV_W-1:0]  status;   // sticky events
    logic [wwpc_pkg::EV_W-1:0]  intEn;    // interrupt enables
    logic                       irq;      // registered interrupt
    logic [31:0]                capRst;   // capacitor-equivalent reset delay
    logic [31:0]                capUpper; // capacitor-equivalent upper bound
    logic                       pready;
    logic [31:0]                prdata;
    logic                       pslverr;
  } wwpc_top_state_t;

  wwpc_top_state_t s;
  wwpc_top_state_t next_s;

  wwpc_pin_if pins ();

  logic [31:0] count;
  logic        cntClear;

  // pin synchronisation and kick edge detection
  wwpc_sync u_sync (
    .ref_clk                   (ref_clk),
    .nrst                      (nrst),
    .window_select_a           (window_select_a),
    .window_select_b           (window_select_b),
    .timeout_program_input     (timeout_program_input),
    .reset_delay_program_input (reset_delay_program_input),
    .kick_input                (kick_input),
    .pins                      (pins)
  );

  // cycle counter shared by all timed phases
  wwpc_cnt u_cnt (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .clear   (cntClear),
    .count   (count)
  );

  // pick a cycle count from the strap code: capacitor, pull-up or open
  function automatic logic [31:0] pickSrc(input logic [1:0] code, input logic [31:0] capVal,
                                          input logic [31:0] pullVal, input logic [31:0] openVal);
    logic [31:0] r;
    r = openVal;
    if (code == wwpc_pkg::SRC_CAP) begin
      r = capVal;
    end else if (code == wwpc_pkg::SRC_PULLUP) begin
      r = pullVal;
    end
    return r;
  endfunction

  // lower boundary as a fraction of the upper, chosen by the selects
  function automatic logic [31:0] lowerOf(input logic [31:0] upper, input logic [1:0] sel);
    logic [31:0] r;
    r = upper >> wwpc_pkg::SHIFT_EIGHTH;
    if (sel == wwpc_pkg::SEL_HALF) begin
      r = upper >> wwpc_pkg::SHIFT_HALF;
    end else if (sel == wwpc_pkg::SEL_QUARTER) begin
      r = upper >> wwpc_pkg::SHIFT_QUARTER;
    end
    return r;
  endfunction

  // last count of a period, guarding a zero length
  function automatic logic [31:0] lastOf(input logic [31:0] len);
    logic [31:0] r;
    r = '0;
    if (len != '0) begin
      r = len - wwpc_pkg::CNT_ONE;
    end
    return r;
  endfunction

  logic [1:0]                sel;
  logic                      enabled;
  logic [31:0]               upper;
  logic [31:0]               lower;
  logic [31:0]               rstLen;
  logic [wwpc_pkg::EV_W-1:0] ev;
  logic [wwpc_pkg::EV_W-1:0] clr;
  logic                      acc;

  // window configuration from the synchronised pins
  always_comb begin
    sel     = {pins.selB, pins.selA};
    enabled = (sel != wwpc_pkg::SEL_DISABLED);
    upper   = pickSrc(pins.timeCode, s.capUpper, UPPER_PULLUP_CYC, UPPER_OPEN_CYC);
    lower   = lowerOf(upper, sel);
    rstLen  = pickSrc(pins.delayCode, s.capRst, RST_PULLUP_CYC, RST_OPEN_CYC);
  end

  // phase machine, event detection, apb slave and interrupt
  always_comb begin
    next_s   = s;
    ev       = '0;
    clr      = '0;
    cntClear = 1'b0;
    acc      = psel & penable & s.pready;

    case (s.phase)
      wwpc_pkg::PH_DISABLED: begin
        next_s.rstOutN = 1'b1;
        cntClear       = 1'b1;
        if (enabled) begin
          next_s.phase = wwpc_pkg::PH_STARTUP;
        end
      end
      wwpc_pkg::PH_STARTUP: begin
        // kicks are not looked at until the start-up delay is over
        if (!enabled) begin
          next_s.phase = wwpc_pkg::PH_DISABLED;
          cntClear     = 1'b1;
        end else if (count >= lastOf(rstLen)) begin
          next_s.phase = wwpc_pkg::PH_WINDOW;
          cntClear     = 1'b1;
        end
      end
      wwpc_pkg::PH_WINDOW: begin
        if (!enabled) begin
          next_s.phase = wwpc_pkg::PH_DISABLED;
          cntClear     = 1'b1;
        end else if (pins.kickFall) begin
          cntClear = 1'b1;
          if (count < lower) begin
            ev[wwpc_pkg::EV_EARLY] = 1'b1;
            next_s.phase           = wwpc_pkg::PH_RESET;
            next_s.rstOutN         = 1'b0;
          end else begin
            ev[wwpc_pkg::EV_KICK] = 1'b1;
          end
        end else if (count >= lastOf(upper)) begin
          ev[wwpc_pkg::EV_LATE] = 1'b1;
          next_s.phase          = wwpc_pkg::PH_RESET;
          next_s.rstOutN        = 1'b0;
          cntClear              = 1'b1;
        end
      end
      wwpc_pkg::PH_RESET: begin
        // kick edges are dropped while the reset is held low
        if (!enabled) begin
          next_s.phase   = wwpc_pkg::PH_DISABLED;
          next_s.rstOutN = 1'b1;
          cntClear       = 1'b1;
        end else if (count >= lastOf(rstLen)) begin
          next_s.phase              = wwpc_pkg::PH_WINDOW;
          next_s.rstOutN            = 1'b1;
          ev[wwpc_pkg::EV_RELEASE]  = 1'b1;
          cntClear                  = 1'b1;
        end
      end
      default: begin
        next_s.phase   = wwpc_pkg::PH_DISABLED;
        next_s.rstOutN = 1'b1;
        cntClear       = 1'b1;
      end
    endcase

    // apb: ready rises one cycle into the access phase, then drops
    next_s.pready  = psel & penable & ~s.pready;
    next_s.pslverr = 1'b0;
    if (psel & penable & ~s.pready) begin
      next_s.prdata = '0;
      case (paddr)
        wwpc_pkg::OFS_STATUS:    next_s.prdata = {{(32-wwpc_pkg::EV_W){1'b0}}, s.status};
        wwpc_pkg::OFS_INT_CLEAR: next_s.prdata = '0;
        wwpc_pkg::OFS_INT_EN:    next_s.prdata = {{(32-wwpc_pkg::EV_W){1'b0}}, s.intEn};
        wwpc_pkg::OFS_CAP_RST:   next_s.prdata = s.capRst;
        wwpc_pkg::OFS_CAP_UPPER: next_s.prdata = s.capUpper;
        wwpc_pkg::OFS_PHASE:     next_s.prdata = {25'h0, pins.delayCode, pins.timeCode, enabled, s.phase};
        wwpc_pkg::OFS_COUNT:     next_s.prdata = count;
        default:                 next_s.pslverr = 1'b1;
      endcase
    end

    // register writes take effect on the completing edge
    if (acc & pwrite) begin
      case (paddr)
        wwpc_pkg::OFS_INT_CLEAR: clr = pwdata[wwpc_pkg::EV_W-1:0];
        wwpc_pkg::OFS_INT_EN:    next_s.intEn = pwdata[wwpc_pkg::EV_W-1:0];
        wwpc_pkg::OFS_CAP_RST:   next_s.capRst = pwdata;
        wwpc_pkg::OFS_CAP_UPPER: next_s.capUpper = pwdata;
        default:                 next_s.intEn = s.intEn;
      endcase
    end

    // sticky status: a new event beats a clear in the same cycle
    next_s.status = (s.status & ~clr) | ev;
    next_s.irq    = |(next_s.status & next_s.intEn);
    next_s.rstOe  = ~next_s.rstOutN;
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s          <= '0;
      s.phase    <= wwpc_pkg::PH_DISABLED;
      s.rstOutN  <= 1'b1;
      s.capRst   <= wwpc_pkg::CAP_RST_RESET;
      s.capUpper <= wwpc_pkg::CAP_UPPER_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign reset_out_n  = s.rstOutN;
  assign reset_out_oe = s.rstOe;
  assign pready       = s.pready;
  assign prdata       = s.prdata;
  assign pslverr      = s.pslverr;
  assign irq          = s.irq;

endmodule

// ==== wwpc_pkg.sv ====
// shared constants, encodings and register map of the window watchdog
package wwpc_pkg;

  // clock rate in MHz, used to turn microseconds into cycles
  localparam int unsigned CLK_MHZ = 200;

  // preset upper window boundaries, in microseconds
  localparam int unsigned UPPER_PULLUP_US = 1000;
  localparam int unsigned UPPER_OPEN_US   = 500;

  // preset reset delays, in microseconds
  localparam int unsigned RST_PULLUP_US = 200;
  localparam int unsigned RST_OPEN_US   = 100;

  // strap codes on the timeout and reset-delay program inputs
  localparam logic [1:0] SRC_CAP    = 2'h0;
  localparam logic [1:0] SRC_PULLUP = 2'h1;

  // window select codes {window_select_b, window_select_a}
  localparam logic [1:0] SEL_DISABLED = 2'h0;
  localparam logic [1:0] SEL_HALF     = 2'h1;
  localparam logic [1:0] SEL_QUARTER  = 2'h2;

  // shift amounts giving lower boundary from upper boundary
  localparam int unsigned SHIFT_HALF    = 1;
  localparam int unsigned SHIFT_QUARTER = 2;
  localparam int unsigned SHIFT_EIGHTH  = 3;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h04;
  localparam logic [7:0] OFS_INT_EN    = 8'h08;
  localparam logic [7:0] OFS_CAP_RST   = 8'h0c;
  localparam logic [7:0] OFS_CAP_UPPER = 8'h10;
  localparam logic [7:0] OFS_PHASE     = 8'h14;
  localparam logic [7:0] OFS_COUNT     = 8'h18;

  // status / interrupt bit positions
  localparam int unsigned EV_LATE    = 0;
  localparam int unsigned EV_EARLY   = 1;
  localparam int unsigned EV_KICK    = 2;
  localparam int unsigned EV_RELEASE = 3;
  localparam int unsigned EV_W       = 4;

  // reset values of the capacitor-equivalent registers, in cycles
  localparam logic [31:0] CAP_RST_RESET   = 32'h0000_4e20;
  localparam logic [31:0] CAP_UPPER_RESET = 32'h0001_86a0;

  // counter step and saturation value
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  localparam logic [31:0] CNT_MAX = 32'hffff_ffff;

  // watchdog phases
  typedef enum logic [1:0] {
    PH_DISABLED = 2'b00,
    PH_STARTUP  = 2'b01,
    PH_WINDOW   = 2'b10,
    PH_RESET    = 2'b11
  } wwpc_phase_t;

endpackage

// ==== wwpc_pin_if.sv ====
// synchronised pin levels and kick edge passed from the synchroniser to the core
`timescale 1ns/1ps
interface wwpc_pin_if;
  logic       selA;      // window_select_a after sync
  logic       selB;      // window_select_b after sync
  logic [1:0] timeCode;  // timeout_program_input strap code after sync
  logic [1:0] delayCode; // reset_delay_program_input strap code after sync
  logic       kickFall;  // one-cycle pulse on a falling kick_input edge

  modport src (output selA, selB, timeCode, delayCode, kickFall);
  modport dst (input  selA, selB, timeCode, delayCode, kickFall);
endinterface

// ==== wwpc_sync.sv ====
// two-stage synchroniser for the pins and falling-edge detector for the kick input
`timescale 1ns/1ps
module wwpc_sync (
  input  wire logic ref_clk,                    // system clock
  input  wire logic nrst,                       // synchronous reset, active low
  input  wire logic window_select_a,            // raw select pin a
  input  wire logic window_select_b,            // raw select pin b
  input  wire logic [1:0] timeout_program_input, // raw timeout strap code
  input  wire logic [1:0] reset_delay_program_input, // raw reset-delay strap code
  input  wire logic kick_input,                 // raw watchdog kick pin
  wwpc_pin_if.src   pins                        // synchronised outputs
);

  typedef struct packed {
    logic [6:0] stage1;  // first flop, read only by stage2
    logic [6:0] stage2;  // second flop, safe to use
    logic       kickOld; // previous synchronised kick level
    logic       kickFall;
  } wwpc_sync_state_t;

  wwpc_sync_state_t s;
  wwpc_sync_state_t next_s;

  // shift pins through the two stages and find a falling kick edge
  always_comb begin
    next_s          = s;
    next_s.stage1   = {kick_input, reset_delay_program_input, timeout_program_input,
                       window_select_b, window_select_a};
    next_s.stage2   = s.stage1;
    next_s.kickOld  = s.stage2[6];
    next_s.kickFall = s.kickOld & ~s.stage2[6];
  end

  // state register; kick idles high so no edge is seen after reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '{stage1: 7'h40, stage2: 7'h40, kickOld: 1'b1, kickFall: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign pins.selA      = s.stage2[0];
  assign pins.selB      = s.stage2[1];
  assign pins.timeCode  = s.stage2[3:2];
  assign pins.delayCode = s.stage2[5:4];
  assign pins.kickFall  = s.kickFall;

endmodule

// ==== wwpc_cnt.sv ====
// saturating cycle counter with synchronous clear
`timescale 1ns/1ps
module wwpc_cnt (
  input  wire logic        ref_clk, // system clock
  input  wire logic        nrst,    // synchronous reset, active low
  input  wire logic        clear,   // restart from zero next cycle
  output logic      [31:0] count    // cycles since last clear
);

  typedef struct packed {
    logic [31:0] count;
  } wwpc_cnt_state_t;

  wwpc_cnt_state_t s;
  wwpc_cnt_state_t next_s;

  // count up, stick at the top, restart on clear
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.count = '0;
    end else if (s.count != wwpc_pkg::CNT_MAX) begin
      next_s.count = s.count + wwpc_pkg::CNT_ONE;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count = s.count;

endmodule

// ==== wwpc_host_model.sv ====
// host processor model that services the watchdog kick pin
`timescale 1ns/1ps
module wwpc_host_model (
  input  wire logic ref_clk,   // system clock
  input  wire logic kickReq,   // bench command to give one kick
  output logic      kick_input // kick pin, always at a defined level
);
  logic [2:0] lowCnt;

  initial begin
    kick_input = 1'b1; // pin driven high from time zero, never floating
    lowCnt     = 3'h0;
  end

  // a kick is a falling edge, held low four cycles so the synchroniser sees it
  always @(posedge ref_clk) begin
    if (kickReq) begin
      kick_input <= 1'b0;
      lowCnt     <= 3'h4;
    end else if (lowCnt != 3'h0) begin
      lowCnt <= lowCnt - 3'h1;
      if (lowCnt == 3'h1) kick_input <= 1'b1;
    end
  end
endmodule

// ==== wwpc_top_monitor.sv ====
// concurrent checks on the watchdog top ports, bound into the top module
`timescale 1ns/1ps
module wwpc_top_monitor (
  input wire logic        ref_clk,                   // system clock
  input wire logic        nrst,                      // synchronous reset, active low
  input wire logic        window_select_a,           // select pin a
  input wire logic        window_select_b,           // select pin b
  input wire logic [1:0]  timeout_program_input,     // timeout strap
  input wire logic [1:0]  reset_delay_program_input, // reset-delay strap
  input wire logic        kick_input,                // kick pin
  input wire logic        reset_out_n,               // watchdog reset
  input wire logic        reset_out_oe,              // open-drain enable
  input wire logic        psel,                      // apb select
  input wire logic        penable,                   // apb enable
  input wire logic        pwrite,                    // apb direction
  input wire logic [7:0]  paddr,                     // apb address
  input wire logic [31:0] pwdata,                    // apb write data
  input wire logic        pready,                    // apb ready
  input wire logic [31:0] prdata,                    // apb read data
  input wire logic        pslverr,                   // apb error
  input wire logic        irq                        // interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // named steps of a release followed by a quiet kick pin
  sequence s_release;
    $rose(reset_out_n);
  endsequence
  sequence s_quiet;
    kick_input [*8];
  endsequence

  chk_oe_mirror: assert property (reset_out_oe == !reset_out_n)
    else $error("open-drain enable does not mirror the reset output");
  chk_off_high: assert property ((!window_select_a && !window_select_b) [*5] |-> reset_out_n)
    else $error("reset output low while the watchdog is off");
  chk_low_hold: assert property ($fell(reset_out_n) |-> (!reset_out_n) [*8])
    else $error("reset pulse shorter than the shortest delay");
  chk_low_ends: assert property ($fell(reset_out_n) |-> ##[1:1000] reset_out_n)
    else $error("reset output never released");
  chk_startup_quiet: assert property ($rose(window_select_a || window_select_b) |-> ##4 reset_out_n [*8])
    else $error("reset output asserted during startup delay");
  chk_no_early_timeout: assert property (s_release ##1 s_quiet |-> reset_out_n)
    else $error("timeout far before the upper boundary");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("apb ready longer than one cycle");
  chk_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("apb ready without an access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("apb error outside a completion");
endmodule

bind wwpc_top wwpc_top_monitor chk (.ref_clk(ref_clk), .nrst(nrst), .window_select_a(window_select_a),
  .window_select_b(window_select_b), .timeout_program_input(timeout_program_input),
  .reset_delay_program_input(reset_delay_program_input), .kick_input(kick_input), .reset_out_n(reset_out_n),
  .reset_out_oe(reset_out_oe), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));

// ==== window_watchdog_pin_control_bench.sv ====
// self-checking testbench of the window watchdog top
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: mismatch on line %0d", $time, `__LINE__); end end
module window_watchdog_pin_control_bench;
  logic        ref_clk = 1'b0, nrst = 1'b0, selA = 1'b0, selB = 1'b0, kickReq = 1'b0, kickPin;
  logic [1:0]  timeCode = 2'h1, delayCode = 2'h1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, resetOutN, resetOutOe;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic        e;
  int          miscompares = 0, num_checks = 0, n;

  // 5 ns clock
  always #2.5 ref_clk = ~ref_clk;

  wwpc_host_model host (.ref_clk(ref_clk), .kickReq(kickReq), .kick_input(kickPin));
  wwpc_top #(.UPPER_PULLUP_CYC(32'h40), .UPPER_OPEN_CYC(32'h30), .RST_PULLUP_CYC(32'h10), .RST_OPEN_CYC(32'h0c)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .window_select_a(selA), .window_select_b(selB),
    .timeout_program_input(timeCode), .reset_delay_program_input(delayCode), .kick_input(kickPin),
    .reset_out_n(resetOutN), .reset_out_oe(resetOutOe), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));

  // one apb transfer, waits for ready, then lets one edge pass
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, d, e);
  endtask
  task automatic chkReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0, d, e);
    `CHK(d & m, x)
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  // counts edges until the reset output shows the level, bounded by lim
  task automatic waitLvl(input logic lvl, input int lim, output int c);
    c = 0;
    while (resetOutN !== lvl && c < lim) begin
      @(posedge ref_clk);
      c++;
    end
  endtask
  task automatic kick();
    kickReq <= 1'b1;
    @(posedge ref_clk);
    kickReq <= 1'b0;
  endtask
  // straps change only while the watchdog is off
  task automatic setMode(input logic [1:0] s, input logic [1:0] t, input logic [1:0] r);
    selA <= 1'b0; selB <= 1'b0;
    idle(8);
    timeCode <= t; delayCode <= r;
    idle(4);
    {selB, selA} <= s;
    @(posedge ref_clk);
  endtask

  // reset values, read-only status, unmapped address, capacitor settings
  task automatic t_regs();
    chkReg(wwpc_pkg::OFS_CAP_RST, 32'hffff_ffff, wwpc_pkg::CAP_RST_RESET);
    chkReg(wwpc_pkg::OFS_CAP_UPPER, 32'hffff_ffff, wwpc_pkg::CAP_UPPER_RESET);
    chkReg(wwpc_pkg::OFS_INT_EN, 32'hffff_ffff, 32'h0);
    wr(wwpc_pkg::OFS_STATUS, 32'hf);
    chkReg(wwpc_pkg::OFS_STATUS, 32'hffff_ffff, 32'h0);
    apb(1'b0, 8'h40, 32'h0, d, e);
    `CHK({e, d}, 33'h1_0000_0000)
    wr(wwpc_pkg::OFS_CAP_RST, 32'h14);
    wr(wwpc_pkg::OFS_CAP_UPPER, 32'h28);
    chkReg(wwpc_pkg::OFS_CAP_UPPER, 32'hffff_ffff, 32'h28);
  endtask

  // watchdog off: kicks leave no trace and reset stays high
  task automatic t_off();
    repeat (3) begin
      kick();
      idle(10);
    end
    waitLvl(1'b0, 60, n);
    `CHK(n, 60)
    chkReg(wwpc_pkg::OFS_STATUS, 32'hf, 32'h0);
    chkReg(wwpc_pkg::OFS_PHASE, 32'h7f, 32'h28);
  endtask

  // pull-up, open and capacitor straps: reset length and timeout period
  task automatic t_timeouts();
    logic [1:0] tc [3] = '{2'h1, 2'h2, 2'h0};
    logic [1:0] dc [3] = '{2'h1, 2'h3, 2'h0};
    int         up [3] = '{64, 48, 40};
    int         lo [3] = '{16, 12, 20};
    for (int k = 0; k < 3; k++) begin
      setMode(2'h1, tc[k], dc[k]);
      waitLvl(1'b0, 400, n);
      `CHK(resetOutOe, 1'b1)
      waitLvl(1'b1, 100, n);
      `CHK(n >= lo[k] && n <= lo[k] + 1, 1'b1)
      waitLvl(1'b0, 200, n);
      `CHK(n >= up[k] - 2 && n <= up[k] + 1, 1'b1)
      waitLvl(1'b1, 100, n);
    end
    chkReg(wwpc_pkg::OFS_STATUS, 32'h9, 32'h9);
  endtask

  // kicks inside the window restart timing; the selects move the lower bound
  task automatic t_kicks();
    logic [1:0]  sl [3] = '{2'h1, 2'h2, 2'h3};
    logic [31:0] ex [3] = '{32'h2, 32'h4, 32'h4};
    int          iw [3] = '{12, 12, 3};
    setMode(2'h1, 2'h1, 2'h1);
    waitLvl(1'b0, 400, n);
    waitLvl(1'b1, 100, n);
    wr(wwpc_pkg::OFS_INT_CLEAR, 32'hf);
    idle(30);
    repeat (4) begin
      kick();
      idle(38);
    end
    waitLvl(1'b0, 15, n);
    `CHK(n, 15)
    chkReg(wwpc_pkg::OFS_STATUS, 32'hf, 32'h4);
    for (int k = 0; k < 3; k++) begin
      setMode(sl[k], 2'h1, 2'h1);
      waitLvl(1'b0, 400, n);
      waitLvl(1'b1, 100, n);
      wr(wwpc_pkg::OFS_INT_CLEAR, 32'hf);
      idle(iw[k]);
      kick();
      idle(30);
      chkReg(wwpc_pkg::OFS_STATUS, 32'h6, ex[k]);
    end
  endtask

  // kicks during startup and during the reset pulse are ignored
  task automatic t_ignore();
    setMode(2'h1, 2'h1, 2'h1);
    idle(5);
    kick();
    waitLvl(1'b0, 400, n);
    `CHK(n >= 70 && n <= 84, 1'b1)
    wr(wwpc_pkg::OFS_INT_CLEAR, 32'hf);
    kick();
    waitLvl(1'b1, 100, n);
    idle(5);
    chkReg(wwpc_pkg::OFS_STATUS, 32'h6, 32'h0);
  endtask

  // interrupt raised by a late timeout, masked and cleared
  task automatic t_irq();
    setMode(2'h0, 2'h1, 2'h1);
    wr(wwpc_pkg::OFS_INT_CLEAR, 32'hf);
    wr(wwpc_pkg::OFS_INT_EN, 32'h1);
    setMode(2'h1, 2'h1, 2'h1);
    waitLvl(1'b0, 400, n);
    waitLvl(1'b1, 100, n);
    selA <= 1'b0;
    idle(8);
    `CHK(irq, 1'b1)
    wr(wwpc_pkg::OFS_INT_EN, 32'h0);
    idle(2);
    `CHK(irq, 1'b0)
    wr(wwpc_pkg::OFS_INT_EN, 32'h1);
    idle(2);
    `CHK(irq, 1'b1)
    wr(wwpc_pkg::OFS_INT_CLEAR, 32'h1);
    idle(2);
    `CHK(irq, 1'b0)
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    idle(10);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_off();
    t_timeouts();
    t_kicks();
    t_ignore();
    t_irq();
    wrap_up();
  end

  // watchdog against a hang, well above the expected few thousand cycles
  initial begin
    idle(20000);
    miscompares++;
    wrap_up();
  end
endmodule
